// ---- hdl/spi_pkg.sv ----
package spi_pkg;

  // one serial byte
  typedef logic [7:0] byte_t;

  // transfer shape: eight bits, two serial clock edges per bit
  localparam int unsigned BITS_PER_XFER  = 8;
  localparam logic [4:0]  EDGES_PER_XFER = 5'h10;
  localparam logic [4:0]  EDGE_CNT_RST   = 5'h00;

  // reset values
  localparam byte_t      DATA_RST    = 8'h00;
  localparam logic [2:0] FIELD_RST   = 3'h0;
  localparam logic [10:0] DIV_CNT_RST = 11'h000;

  // bus clock and bit-rate ceilings, in bus clocks per serial bit
  localparam int unsigned BUS_CLK_MHZ        = 250;
  localparam int unsigned MASTER_MIN_CLK_DIV = 2;
  localparam int unsigned SLAVE_MIN_CLK_DIV  = 4;

  // master divider: prescale 1..8 times 2^(rate+1); this gives the full period
  localparam logic [10:0] DIV_ONE = 11'h001;

  // transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } xfer_state_e;

  // bus clocks per half serial clock period
  function automatic logic [10:0] half_period(input logic [2:0] presc, input logic [2:0] rate);
    logic [10:0] base;
    base = {8'h00, presc} + DIV_ONE;
    return base << rate;
  endfunction

endpackage

// ---- hdl/spi_rate_div.sv ----
module spi_rate_div
  import spi_pkg::*;
(
  input  wire logic       clk_i,       // bus clock
  input  wire logic       reset_n_i,   // sync reset, active low
  input  wire logic       restart_i,   // hold counter at zero
  input  wire logic [2:0] presc_i,     // prescale select field
  input  wire logic [2:0] rate_i,      // rate select field
  output logic            tick_o       // one pulse per half serial period
);

  logic [10:0] cnt_ff;
  logic        last;

  // final count of each half period
  assign last   = (cnt_ff == half_period(presc_i, rate_i) - DIV_ONE);
  assign tick_o = last && !restart_i;

  // half-period counter, restarted between transfers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || restart_i || last) begin
      cnt_ff <= DIV_CNT_RST;
    end else begin
      cnt_ff <= cnt_ff + DIV_ONE;
    end
  end

endmodule // spi_rate_div

// ---- hdl/spi_master_slave_port.sv ----
// Notes on behaviour
// - master bit rate at most bus clock over two; slave at most over four.
// - only the master starts transfers; both shifters exchange their bytes.
// - master drives the serial clock; slave only receives it.
// - slave takes part only while its select input is low.
// - written byte waits in a transmit buffer until the next transfer starts.
// - a finished byte is copied into a receive buffer for reading, unless an unread byte is still there and is not read in that cycle.
// - master drives clock and master data out, samples master data in.
// - slave clocks from the pin, drives slave data out, samples master data.
// - bus clock first divided by a prescale of 1 to 8.
// - prescaler output divided again by 2 up to 256.
// - with the module disabled all four pins are released and ignored.
// - bidirectional master uses one data pin directed by its output enable.
// - bidirectional slave uses the other data pin directed by its output enable.
// - master select pin: port, fault input, or automatic select output.
// - in slave mode the select pin is always the active-low select input.
// - the module stops working in every stop mode.
// - leaving deep stop, every state element is in its reset value.
// - light stop holds state; reset exit resets, interrupt exit resumes.
// - software controls options, rate, status and data through five byte registers.
// - polarity bit inverts the serial clock and its idle level.
// - phase bit puts first clock edge mid-bit or at bit start.
// - direction bit selects most or least significant bit first.
// - disabling aborts, clears buffers, clears receive-full, sets transmit-empty.
module spi_master_slave_port
(
  input  wire logic          clk_i,                 // bus clock
  input  wire logic          reset_n_i,             // sync reset, active low
  // low-power state
  input  wire logic          light_stop_i,          // light stop: clocks halted, state held
  input  wire logic          deep_stop_i,           // deep stop: module powered down
  // option and rate controls
  input  wire logic          module_enable_i,       // module enable bit
  input  wire logic          master_select_i,       // 1 master, 0 slave
  input  wire logic          clock_polarity_i,      // 1 clock idles high
  input  wire logic          clock_phase_i,         // 1 first edge at bit start
  input  wire logic          shift_direction_i,     // 1 lsb first
  input  wire logic          select_output_en_i,    // select output enable bit
  input  wire logic          mode_fault_en_i,       // mode fault enable bit
  input  wire logic          bidir_pin_control_i,   // single-wire data mode
  input  wire logic          bidir_output_en_i,     // single data pin direction
  input  wire logic [2:0]    prescale_select_i,     // prescale divisor minus one
  input  wire logic [2:0]    rate_select_i,         // rate divider exponent minus one
  // serial data register access
  input  wire logic          data_wr_i,             // write pulse to data register
  input  wire spi_pkg::byte_t data_wdata_i,         // byte written
  input  wire logic          data_rd_i,             // read pulse from data register
  output spi_pkg::byte_t     data_rdata_o,          // receive buffer contents
  // status
  input  wire logic          mode_fault_clr_i,      // clears mode fault flag
  output logic               receive_full_o,        // receive buffer holds unread byte
  output logic               transmit_empty_o,      // transmit buffer may be written
  output logic               mode_fault_o,          // sticky mode fault flag
  output logic               busy_o,                // byte being shifted
  // serial clock pin
  input  wire logic          sclk_i,                // pin level
  output logic               sclk_o,                // driven level
  output logic               sclk_oe_n_o,           // low while driven
  // master data out / slave data in pin
  input  wire logic          mosi_i,                // pin level
  output logic               mosi_o,                // driven level
  output logic               mosi_oe_n_o,           // low while driven
  // master data in / slave data out pin
  input  wire logic          miso_i,                // pin level
  output logic               miso_o,                // driven level
  output logic               miso_oe_n_o,           // low while driven
  // slave select pin
  input  wire logic          ss_n_i,                // pin level, select active low
  output logic               ss_n_o,                // driven level
  output logic               ss_oe_n_o              // low while driven
);

  import spi_pkg::*;

  xfer_state_e state_ff;
  logic [4:0]  cnt_ff;
  byte_t       sh_ff;
  byte_t       nxt_sh;
  byte_t       tx_buf_ff;
  byte_t       rx_buf_ff;
  logic        tx_empty_ff;
  logic        rx_full_ff;
  logic        modf_ff;
  logic        cap_ff;
  logic        sclk_ff;
  logic        sclk_prev_ff;
  logic        mst_ff;
  logic        clock_polarity_bit_ff;
  logic        clock_phase_bit_ff;
  logic        lsb_ff;

  logic        clear_all;
  logic        halt;
  logic        idle;
  logic        in_xfer;
  logic        fault;
  logic        din;
  logic        tick;
  logic        edge_ev;
  logic        start;
  logic        abort;
  logic        step;
  logic        done;
  logic        samp;
  logic        shft;
  logic        in_bit;
  logic        out_bit;
  logic [4:0]  nxt_cnt;

  // deep stop acts as a full reset, light stop freezes every register except the pin drivers, which are released, and the divider counter, held at zero
  assign clear_all = !reset_n_i || deep_stop_i;
  assign halt      = light_stop_i;

  assign idle    = (state_ff == ST_IDLE);
  assign in_xfer = (state_ff == ST_XFER);

  // master with fault input: a low select pin means another master
  assign fault = mst_ff && mode_fault_en_i && !select_output_en_i && !ss_n_i;

  // shifter input routing per mode
  always_comb begin
    if (mst_ff) begin
      din = bidir_pin_control_i ? mosi_i : miso_i;
    end else begin
      din = bidir_pin_control_i ? miso_i : mosi_i;
    end
  end

  // master half-period ticks; counter waits at zero between bytes
  spi_rate_div spi_rate_div_i (
    .clk_i     (clk_i),
    .reset_n_i (!clear_all),
    .restart_i (idle || halt),
    .presc_i   (prescale_select_i),
    .rate_i    (rate_select_i),
    .tick_o    (tick)
  );

  // serial clock edges: own ticks as master, pin transitions as slave
  assign edge_ev = mst_ff ? tick : (sclk_i != sclk_prev_ff);

  // transfer start, abort and edge bookkeeping
  always_comb begin
    start = 1'b0;
    if (idle && module_enable_i) begin
      if (mst_ff) begin
        start = !tx_empty_ff && !fault;
      end else begin
        start = !ss_n_i;
      end
    end
  end

  assign abort   = in_xfer && (!module_enable_i || fault || (!mst_ff && ss_n_i));
  assign step    = in_xfer && edge_ev && !abort;
  assign nxt_cnt = cnt_ff + 5'h01;
  assign done    = step && (nxt_cnt == EDGES_PER_XFER);
  assign samp    = step && (clock_phase_bit_ff ? !nxt_cnt[0] : nxt_cnt[0]);
  assign shft    = step && (clock_phase_bit_ff ? ((nxt_cnt[0] && (nxt_cnt != 5'h01)) || done) : !nxt_cnt[0]);
  assign in_bit  = (clock_phase_bit_ff && done) ? din : cap_ff;
  assign out_bit = lsb_ff ? sh_ff[0] : sh_ff[7];

  // next shifter contents
  always_comb begin
    nxt_sh = sh_ff;
    if (!module_enable_i) begin
      nxt_sh = DATA_RST;
    end else if (start) begin
      nxt_sh = tx_empty_ff ? sh_ff : tx_buf_ff;
    end else if (shft) begin
      nxt_sh = lsb_ff ? {in_bit, sh_ff[7:1]} : {sh_ff[6:0], in_bit};
    end
  end

  // configuration copied only while idle
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      mst_ff  <= 1'b0;
      clock_polarity_bit_ff <= 1'b0;
      clock_phase_bit_ff <= 1'b0;
      lsb_ff  <= 1'b0;
    end else if (!halt && idle) begin
      mst_ff  <= master_select_i;
      clock_polarity_bit_ff <= clock_polarity_i;
      clock_phase_bit_ff <= clock_phase_i;
      lsb_ff  <= shift_direction_i;
    end
  end

  // sequencer state and edge counter
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= EDGE_CNT_RST;
    end else if (!halt) begin
      unique case (state_ff)
        ST_IDLE: begin
          cnt_ff <= EDGE_CNT_RST;
          if (start) begin
            state_ff <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (abort || done) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= EDGE_CNT_RST;
          end else if (step) begin
            cnt_ff <= nxt_cnt;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          cnt_ff   <= EDGE_CNT_RST;
        end
      endcase
    end
  end

  // shifter and captured input bit
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      sh_ff  <= DATA_RST;
      cap_ff <= 1'b0;
    end else if (!halt) begin
      sh_ff <= nxt_sh;
      if (samp) begin
        cap_ff <= din;
      end
    end
  end

  // transmit buffer; a write is taken only while the buffer is empty
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      tx_buf_ff   <= DATA_RST;
      tx_empty_ff <= 1'b1;
    end else if (!halt) begin
      if (!module_enable_i) begin
        tx_buf_ff   <= DATA_RST;
        tx_empty_ff <= 1'b1;
      end else if (data_wr_i && tx_empty_ff) begin
        tx_buf_ff   <= data_wdata_i;
        tx_empty_ff <= 1'b0;
      end else if (start && !tx_empty_ff) begin
        tx_empty_ff <= 1'b1;
      end
    end
  end

  // receive buffer; a finished byte beats a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      rx_buf_ff  <= DATA_RST;
      rx_full_ff <= 1'b0;
    end else if (!halt) begin
      if (!module_enable_i) begin
        rx_buf_ff  <= DATA_RST;
        rx_full_ff <= 1'b0;
      end else if (done) begin
        rx_full_ff <= 1'b1;
        if (!rx_full_ff || data_rd_i) begin
          rx_buf_ff <= nxt_sh;
        end
      end else if (data_rd_i) begin
        rx_full_ff <= 1'b0;
      end
    end
  end

  // sticky mode fault; set wins over clear
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      modf_ff <= 1'b0;
    end else if (!halt) begin
      if (module_enable_i && fault) begin
        modf_ff <= 1'b1;
      end else if (mode_fault_clr_i) begin
        modf_ff <= 1'b0;
      end
    end
  end

  // master clock level and slave pin history
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      sclk_ff      <= 1'b0;
      sclk_prev_ff <= 1'b0;
    end else if (!halt) begin
      sclk_prev_ff <= sclk_i;
      if (idle || abort || done) begin
        sclk_ff <= idle ? clock_polarity_i : clock_polarity_bit_ff;
      end else if (step) begin
        sclk_ff <= !sclk_ff;
      end
    end
  end

  // pin drivers, released whenever disabled or stopped
  always_ff @(posedge clk_i) begin
    if (clear_all || halt || !module_enable_i) begin
      sclk_o      <= 1'b0;
      sclk_oe_n_o <= 1'b1;
      mosi_o      <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
      ss_n_o      <= 1'b1;
      ss_oe_n_o   <= 1'b1;
    end else if (mst_ff) begin
      sclk_o      <= sclk_ff;
      sclk_oe_n_o <= 1'b0;
      mosi_o      <= (idle && !ss_n_o) ? mosi_o : out_bit;
      mosi_oe_n_o <= bidir_pin_control_i && !bidir_output_en_i;
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
      ss_n_o      <= !in_xfer && (ss_n_o || (sclk_o == clock_polarity_bit_ff));
      ss_oe_n_o   <= !(mode_fault_en_i && select_output_en_i);
    end else begin
      sclk_o      <= 1'b0;
      sclk_oe_n_o <= 1'b1;
      mosi_o      <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      miso_o      <= out_bit;
      miso_oe_n_o <= ss_n_i || (bidir_pin_control_i && !bidir_output_en_i);
      ss_n_o      <= 1'b1;
      ss_oe_n_o   <= 1'b1;
    end
  end

  // status and data outputs straight from registers
  assign data_rdata_o     = rx_buf_ff;
  assign receive_full_o   = rx_full_ff;
  assign transmit_empty_o = tx_empty_ff;
  assign mode_fault_o     = modf_ff;
  assign busy_o           = state_ff[1];

endmodule // spi_master_slave_port

// ---- tb/spi_master_slave_port_monitor.sv ----
module spi_master_slave_port_monitor (
  input wire logic       clk_i,               // bus clock
  input wire logic       reset_n_i,           // sync reset
  input wire logic       deep_stop_i,         // deep stop
  input wire logic       light_stop_i,        // light stop
  input wire logic       module_enable_i,     // enable
  input wire logic       master_select_i,     // master
  input wire logic       mode_fault_en_i,     // fault enable
  input wire logic       select_output_en_i,  // auto select
  input wire logic       bidir_pin_control_i, // single wire
  input wire logic [2:0] prescale_select_i,   // prescale
  input wire logic [2:0] rate_select_i,       // rate
  input wire logic       data_wr_i,           // write
  input wire logic       data_rd_i,           // read
  input wire logic       ss_n_i,              // select pin
  input wire logic       transmit_empty_o,    // tx empty
  input wire logic       receive_full_o,      // rx full
  input wire logic       mode_fault_o,        // fault
  input wire logic       busy_o,              // busy
  input wire logic       sclk_o,              // clock out
  input wire logic       sclk_oe_n_o,         // clock oe
  input wire logic       mosi_oe_n_o,         // mosi oe
  input wire logic       miso_oe_n_o,         // miso oe
  input wire logic       ss_n_o,              // select out
  input wire logic       ss_oe_n_o            // select oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || deep_stop_i);
  logic        on;
  logic        tgl_seen;
  logic        sclk_q;
  logic [10:0] gap;
  logic [10:0] half;
  // running and expected half period
  assign on   = module_enable_i && !light_stop_i;
  assign half = ({8'h00, prescale_select_i} + 11'h001) << rate_select_i;
  // cycles since the last serial clock change
  always_ff @(posedge clk_i) begin
    sclk_q   <= sclk_o;
    gap      <= (sclk_o != sclk_q) ? 11'h001 : gap + 11'h001;
    tgl_seen <= busy_o && (tgl_seen || (sclk_o != sclk_q));
  end
  property p_off_release;
    !module_enable_i |=> sclk_oe_n_o && mosi_oe_n_o && miso_oe_n_o && ss_oe_n_o;
  endproperty
  a_off_release: assert property (p_off_release) else $error("pin driven while disabled");
  property p_off_flags;
    !module_enable_i && !light_stop_i |=> transmit_empty_o && !receive_full_o && !busy_o;
  endproperty
  a_off_flags: assert property (p_off_flags) else $error("flags wrong after disable");
  property p_master_pins;
    on && master_select_i && !bidir_pin_control_i && busy_o ##1 on |-> !sclk_oe_n_o && !mosi_oe_n_o && miso_oe_n_o;
  endproperty
  a_master_pins: assert property (p_master_pins) else $error("master pin routing wrong");
  property p_slave_pins;
    (on && !master_select_i && !bidir_pin_control_i && !ss_n_i) [*3] |-> !miso_oe_n_o && sclk_oe_n_o && mosi_oe_n_o;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave pin routing wrong");
  property p_ss_auto;
    (on && master_select_i && mode_fault_en_i && select_output_en_i && busy_o) [*2] |-> !ss_oe_n_o && !ss_n_o;
  endproperty
  a_ss_auto: assert property (p_ss_auto) else $error("select not driven low");
  property p_ss_port;
    (on && master_select_i && !mode_fault_en_i) [*2] |-> ss_oe_n_o;
  endproperty
  a_ss_port: assert property (p_ss_port) else $error("select pin not released");
  property p_fault;
    on && master_select_i && mode_fault_en_i && !select_output_en_i && !ss_n_i |=> mode_fault_o;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not flagged");
  property p_tx_take;
    data_wr_i && transmit_empty_o && on |=> !transmit_empty_o;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("write not buffered");
  property p_rd_clear;
    data_rd_i && !busy_o && on |=> !receive_full_o;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read left receive full");
  property p_half;
    on && master_select_i && busy_o && tgl_seen && (sclk_o != sclk_q) |-> gap == half;
  endproperty
  a_half: assert property (p_half) else $error("serial clock half period wrong");
  c_xfer: cover property ($fell(busy_o) && receive_full_o);
  c_fault: cover property ($rose(mode_fault_o));
  c_slave: cover property (!miso_oe_n_o && !master_select_i);
endmodule // spi_master_slave_port_monitor

bind spi_master_slave_port spi_master_slave_port_monitor spi_master_slave_port_monitor_i (.*);

// ---- tb/spi_slave_model.sv ----
module spi_slave_model (
  input  wire logic       clk_i,  // bus clock
  input  wire logic       sclk_i, // serial clock pin
  input  wire logic       mosi_i, // data from master
  input  wire logic       ss_n_i, // select, active low
  input  wire logic       clock_polarity_bit_i, // clock idle level
  input  wire logic       clock_phase_bit_i, // 1 sample on trailing edge
  input  wire logic [7:0] tx_i,   // byte to send
  output logic            miso_o, // data to master
  output logic [7:0]      rx_o    // byte received
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sclk_q;
  logic       ss_q;
  logic [7:0] sh;
  logic       lead;
  logic       trail;
  initial miso_o = 1'b0;
  // leading edge leaves the idle level, trailing edge returns to it
  assign lead  = (sclk_i != sclk_q) && (sclk_q == clock_polarity_bit_i);
  assign trail = (sclk_i != sclk_q) && (sclk_q != clock_polarity_bit_i);
  // msb-first exchange while selected, clock only listened to; data out toggles while deselected
  always @(posedge clk_i) begin
    sclk_q <= sclk_i;
    ss_q   <= ss_n_i;
    if (ss_n_i) begin
      miso_o <= ~miso_o;
    end else if (ss_q) begin
      sh     <= tx_i;
      miso_o <= tx_i[7];
    end else if (clock_phase_bit_i ? trail : lead) begin
      sh   <= {sh[6:0], mosi_i};
      rx_o <= {sh[6:0], mosi_i};
    end else if (clock_phase_bit_i ? lead : trail) begin
      miso_o <= sh[7];
    end
  end
endmodule // spi_slave_model

// ---- tb/spi_master_slave_port_bench.sv ----
module spi_master_slave_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import spi_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, light_stop_i = 1'b0, deep_stop_i = 1'b0, module_enable_i = 1'b0;
  logic master_select_i = 1'b1, clock_polarity_i = 1'b0, clock_phase_i = 1'b0, shift_direction_i = 1'b0;
  logic select_output_en_i = 1'b1, mode_fault_en_i = 1'b1, bidir_pin_control_i = 1'b0, bidir_output_en_i = 1'b0;
  logic data_wr_i = 1'b0, data_rd_i = 1'b0, mode_fault_clr_i = 1'b0, sclk_ext = 1'b0, mosi_ext = 1'b0, ss_ext = 1'b1;
  logic [2:0] prescale_select_i = 3'h0, rate_select_i = 3'h0;
  byte_t data_wdata_i = 8'h00, mdl_tx = 8'h00, data_rdata_o, mdl_rx, got;
  logic receive_full_o, transmit_empty_o, mode_fault_o, busy_o, sclk_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o;
  logic miso_o, miso_oe_n_o, ss_n_o, ss_oe_n_o, mdl_miso;
  int n_errors = 0, cmp_count = 0;
  // pin levels from all drivers
  wire logic sclk_i = sclk_oe_n_o ? sclk_ext : sclk_o;
  wire logic mosi_i = mosi_oe_n_o ? mosi_ext : mosi_o;
  wire logic miso_i = miso_oe_n_o ? mdl_miso : miso_o;
  wire logic ss_n_i = ss_oe_n_o ? ss_ext : ss_n_o;
  spi_master_slave_port spi_master_slave_port_i (.*);
  spi_slave_model spi_slave_model_i (.clk_i, .sclk_i, .mosi_i, .ss_n_i, .clock_polarity_bit_i(clock_polarity_i),
                                     .clock_phase_bit_i(clock_phase_i), .tx_i(mdl_tx), .miso_o(mdl_miso), .rx_o(mdl_rx));
  always #2 clk_i = ~clk_i;
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input byte_t b);
    @(posedge clk_i);
    data_wr_i    <= 1'b1;
    data_wdata_i <= b;
    @(posedge clk_i);
    data_wr_i <= 1'b0;
  endtask
  task automatic rd();
    @(posedge clk_i);
    data_rd_i <= 1'b1;
    @(posedge clk_i);
    data_rd_i <= 1'b0;
    @(posedge clk_i);
    check(receive_full_o, 1'b0);
  endtask
  // one master byte, counting serial clock changes for a fixed span
  task automatic xfer(input logic [2:0] p, r, input byte_t tb, mb, eb, em);
    int   edges;
    logic last;
    prescale_select_i <= p;
    rate_select_i     <= r;
    mdl_tx            <= mb;
    wr(tb);
    edges = 0;
    last  = sclk_o;
    repeat ((18 << r) * (p + 1) + 20) begin
      @(posedge clk_i);
      edges += int'(sclk_o !== last);
      last = sclk_o;
    end
    check(11'(edges), 11'h010);
    check(receive_full_o, 1'b1);
    check(sclk_o, clock_polarity_i);
    check(mdl_rx, em);
    check(data_rdata_o, eb);
    rd();
  endtask
  initial begin
    cyc(2);
    reset_n_i <= 1'b1;
    cyc(2);
    check({transmit_empty_o, receive_full_o, sclk_oe_n_o, mosi_oe_n_o, miso_oe_n_o, ss_oe_n_o}, 6'h2f);
    module_enable_i <= 1'b1;
    cyc(3);
    check({sclk_oe_n_o, mosi_oe_n_o, miso_oe_n_o, sclk_o}, 4'h2);
    xfer(3'h1, 3'h1, 8'ha5, 8'h3c, 8'h3c, 8'ha5);
    xfer(3'h7, 3'h0, 8'h01, 8'h80, 8'h80, 8'h01);
    xfer(3'h0, 3'h2, 8'hf0, 8'h0f, 8'h0f, 8'hf0);
    xfer(3'h7, 3'h7, 8'h5a, 8'hc6, 8'hc6, 8'h5a);
    shift_direction_i <= 1'b1;
    cyc(2);
    xfer(3'h1, 3'h1, 8'h1e, 8'h12, 8'h48, 8'h78);
    shift_direction_i <= 1'b0;
    clock_polarity_i  <= 1'b1;
    cyc(4);
    check(sclk_o, 1'b1);
    xfer(3'h1, 3'h1, 8'h96, 8'h2d, 8'h2d, 8'h96);
    clock_phase_i <= 1'b1;
    cyc(2);
    xfer(3'h0, 3'h2, 8'hc5, 8'h3a, 8'h3a, 8'hc5);
    clock_polarity_i <= 1'b0;
    cyc(4);
    xfer(3'h1, 3'h1, 8'h69, 8'he1, 8'he1, 8'h69);
    clock_phase_i       <= 1'b0;
    bidir_pin_control_i <= 1'b1;
    cyc(3);
    check({mosi_oe_n_o, miso_oe_n_o}, 2'h3);
    bidir_output_en_i <= 1'b1;
    cyc(3);
    check({mosi_oe_n_o, miso_oe_n_o}, 2'h1);
    bidir_pin_control_i <= 1'b0;
    bidir_output_en_i   <= 1'b0;
    // abort a byte by disabling
    wr(8'h55);
    cyc(10);
    module_enable_i <= 1'b0;
    cyc(3);
    check({transmit_empty_o, receive_full_o, busy_o, sclk_oe_n_o, mosi_oe_n_o, ss_oe_n_o}, 6'h27);
    module_enable_i    <= 1'b1;
    select_output_en_i <= 1'b0;
    ss_ext             <= 1'b0;
    cyc(4);
    check(mode_fault_o, 1'b1);
    ss_ext           <= 1'b1;
    mode_fault_clr_i <= 1'b1;
    mode_fault_en_i  <= 1'b0;
    cyc(1);
    mode_fault_clr_i <= 1'b0;
    cyc(3);
    check({mode_fault_o, ss_oe_n_o}, 2'h1);
    light_stop_i <= 1'b1;
    cyc(3);
    check({sclk_oe_n_o, mosi_oe_n_o}, 2'h3);
    light_stop_i <= 1'b0;
    // deep stop in mid-byte
    wr(8'h77);
    cyc(6);
    deep_stop_i <= 1'b1;
    cyc(2);
    deep_stop_i <= 1'b0;
    cyc(2);
    check({transmit_empty_o, receive_full_o, busy_o, data_rdata_o}, 11'h400);
    // slave byte driven by the bench as master, half period of four cycles
    master_select_i <= 1'b0;
    cyc(3);
    check({sclk_oe_n_o, mosi_oe_n_o, miso_oe_n_o}, 3'h7);
    wr(8'hc3);
    ss_ext <= 1'b0;
    cyc(4);
    for (int i = 7; i >= 0; i--) begin
      mosi_ext <= i[0];
      cyc(4);
      sclk_ext <= 1'b1;
      got[i] = miso_i;
      cyc(4);
      sclk_ext <= 1'b0;
    end
    cyc(4);
    ss_ext <= 1'b1;
    cyc(4);
    check(got, 8'hc3);
    check({receive_full_o, data_rdata_o}, 9'h1aa);
    final_report();
  end
  // hang guard
  initial begin
    cyc(60000);
    n_errors++;
    final_report();
  end
endmodule // spi_master_slave_port_bench
